// >>> shared/adc_coding_pkg.sv
// package: constants and carriers for the dual converter configuration and coding block
package adc_coding_pkg;

	// ------------------------------------------------------------
	// code widths and frame counts
	// ------------------------------------------------------------
	localparam int CODE_W           = 16;
	localparam int OP_W             = 4;
	localparam int EDGES_DUAL       = 32;
	localparam int EDGES_SINGLE     = 48;
	localparam int EDGE_CNT_W       = 7;

	// ------------------------------------------------------------
	// configuration word fields
	// ------------------------------------------------------------
	localparam int CFG_MODE_LO      = 10;
	localparam int CFG_MODE_HI      = 11;
	localparam int CFG_RANGE_BIT    = 9;
	localparam int CFG_PSEUDO_BIT   = 7;
	localparam int CFG_INTREF_BIT   = 6;
	localparam int CFG_TWOS_BIT     = 4;
	localparam int REF_DATA_LSB     = 3;
	localparam int REF_DATA_W       = 9;

	// ------------------------------------------------------------
	// values after reset
	// ------------------------------------------------------------
	localparam logic [11:0] CFG_RESET     = 12'h000;
	localparam logic [8:0]  REF_RESET     = 9'h000;

	// ------------------------------------------------------------
	// named codes
	// ------------------------------------------------------------
	localparam logic [15:0] ZERO_CODE          = 16'h0000;
	localparam logic [15:0] MID_CODE           = 16'h7fff;
	localparam logic [15:0] FULL_SCALE_CODE    = 16'hffff;
	localparam logic [15:0] NEG_FULL_SCALE_CODE = 16'h8000;
	localparam logic [15:0] POS_FULL_SCALE_CODE = 16'h7fff;

	// ------------------------------------------------------------
	// command operations (upper four bits)
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP       = 4'h0,
		OP_RD_REF_A  = 4'h1,
		OP_RD_REF_B  = 4'h2,
		OP_RD_CFG    = 4'h3,
		OP_WR_CFG    = 4'h8,
		OP_WR_REF_A  = 4'h9,
		OP_WR_REF_B  = 4'ha
	} op_t;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic       pseudoDiff;
		logic       doubleRange;
		logic       twosComp;
		logic       intRef;
		logic [1:0] ifMode;
	} cfg_view_t;

	typedef struct packed {
		logic [15:0] codeA;
		logic [15:0] codeB;
	} result_pair_t;

endpackage : adc_coding_pkg

// >>> hdl/output_coder.sv
// module: maps one raw sample to a 16-bit output code
`timescale 1ns/100ps
`default_nettype none
module output_coder (
	// clock and control
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        clkEn,
	input  wire logic        sampleValid,
	// format select
	input  wire logic        twosComp,
	// sample as signed distance above the low end, 17 bits
	input  wire logic [16:0] rawSample,
	// coded result
	output logic      [15:0] code
);

	// ------------------------------------------------------------
	// saturation and format
	// ------------------------------------------------------------
	// negatives clamp to zero code, other values pass through as their low 16 bits
	function automatic logic [15:0] saturate(input logic [16:0] s);
		if (s[16])
			return adc_coding_pkg::ZERO_CODE;
		return s[15:0];
	endfunction : saturate

	logic [15:0] binCode;
	assign binCode = saturate(rawSample);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			code <= adc_coding_pkg::ZERO_CODE;
		end else if (clkEn && sampleValid) begin
			// only the top bit differs between formats
			code <= twosComp ? {~binCode[15], binCode[14:0]} : binCode;
		end
	end

endmodule : output_coder
`default_nettype wire

// >>> hdl/adc_config_coding.sv
// module: configuration registers, serial command decode and result coding
// ------------------------------------------------------------
// Notes on behaviour
// - bit 7 clear: single-ended, ground reference
// - bit 7 set: pseudo-differential, midscale negative
// - one input-mode bit shared by both channels
// - bit 4 clear: straight binary results
// - bit 4 set: two's complement results
// - sixteen-bit codes, step is range over 65536
// - binary codes 0000, 7fff, ffff saturating
// - two's complement 8000, 0000, 7fff saturating
// - pseudo-differential zero difference gives midscale
// - range and input mode combine independently
// - three writable, readable user registers
// - top nibble selects write, read or no-op
// - writes apply at frame end if edges sufficient
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module adc_config_coding #(
	parameter int CODE_W = adc_coding_pkg::CODE_W
) (
	// clock, reset, enable
	input  wire logic                        sys_clk,
	input  wire logic                        reset,
	input  wire logic                        clkEn,
	// serial command pins (asynchronous to sys_clk)
	input  wire logic                        serialClk,
	input  wire logic                        chipSelN,
	input  wire logic                        serial_cmd_in,
	// converter samples, unsigned over the selected range, plus flag
	input  wire logic                        sampleValid,
	input  wire logic [CODE_W-1:0]           pos_input_a,
	input  wire logic [CODE_W-1:0]           neg_input_a,
	input  wire logic [CODE_W-1:0]           pos_input_b,
	input  wire logic [CODE_W-1:0]           neg_input_b,
	// coded results
	output adc_coding_pkg::result_pair_t     result,
	// register contents and readback
	output logic [11:0]                      config_word_reg,
	output logic [8:0]                       ref_level_a_reg,
	output logic [8:0]                       ref_level_b_reg,
	output logic [15:0]                      readbackWord,
	output adc_coding_pkg::cfg_view_t        cfgView
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] sclkSync;
	logic [1:0] csSync;
	logic [1:0] dinSync;
	logic       sclkLast;
	logic       csLast;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sclkSync <= 2'h0;
			csSync   <= 2'h3;
			dinSync  <= 2'h0;
		end else if (clkEn) begin
			sclkSync <= {sclkSync[0], serialClk};
			csSync   <= {csSync[0], chipSelN};
			dinSync  <= {dinSync[0], serial_cmd_in};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sclkLast <= 1'b0;
			csLast   <= 1'b1;
		end else if (clkEn) begin
			sclkLast <= sclkSync[1];
			csLast   <= csSync[1];
		end
	end

	logic sclkFall;
	logic csRise;
	logic csFall;
	assign sclkFall = clkEn && sclkLast && !sclkSync[1] && !csSync[1];
	assign csRise   = clkEn && !csLast && csSync[1];
	assign csFall   = clkEn && csLast && !csSync[1];

	// ------------------------------------------------------------
	// frame capture
	// ------------------------------------------------------------
	// pin sampling limits the serial clock to well under sys_clk / 4
	logic [15:0]                      shiftIn;
	logic [adc_coding_pkg::EDGE_CNT_W-1:0] edgeCount;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			shiftIn   <= 16'h0000;
			edgeCount <= '0;
		end else if (csFall) begin
			shiftIn   <= 16'h0000;
			edgeCount <= '0;
		end else if (sclkFall) begin
			if (edgeCount < 7'(CODE_W))
				shiftIn <= {shiftIn[14:0], dinSync[1]};
			// saturate so long frames do not wrap
			if (edgeCount != '1)
				edgeCount <= edgeCount + 7'h01;
		end
	end

	// ------------------------------------------------------------
	// command decode and validation
	// ------------------------------------------------------------
	function automatic logic [6:0] edgesNeeded(input logic [1:0] ifMode);
		return (ifMode == 2'h1) ? 7'(adc_coding_pkg::EDGES_SINGLE)
		                        : 7'(adc_coding_pkg::EDGES_DUAL);
	endfunction : edgesNeeded

	adc_coding_pkg::op_t op;
	logic                frameValid;
	assign op         = adc_coding_pkg::op_t'(shiftIn[15:12]);
	assign frameValid = csRise && (edgeCount >= edgesNeeded(cfgView.ifMode));

	// ------------------------------------------------------------
	// user registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			config_word_reg <= adc_coding_pkg::CFG_RESET;
		end else if (frameValid && op == adc_coding_pkg::OP_WR_CFG) begin
			config_word_reg <= shiftIn[11:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ref_level_a_reg <= adc_coding_pkg::REF_RESET;
			ref_level_b_reg <= adc_coding_pkg::REF_RESET;
		end else if (frameValid) begin
			if (op == adc_coding_pkg::OP_WR_REF_A)
				ref_level_a_reg <= shiftIn[11:3];
			if (op == adc_coding_pkg::OP_WR_REF_B)
				ref_level_b_reg <= shiftIn[11:3];
		end
	end

	// selected word stands until the next valid read command
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			readbackWord <= 16'h0000;
		end else if (frameValid) begin
			unique case (op)
				adc_coding_pkg::OP_RD_CFG:
					readbackWord <= {4'h3, config_word_reg};
				adc_coding_pkg::OP_RD_REF_A:
					readbackWord <= {4'h1, ref_level_a_reg, 3'h0};
				adc_coding_pkg::OP_RD_REF_B:
					readbackWord <= {4'h2, ref_level_b_reg, 3'h0};
				default:
					readbackWord <= readbackWord;
			endcase
		end
	end

	// one copy of every mode bit, shared by both channels
	assign cfgView.pseudoDiff  = config_word_reg[adc_coding_pkg::CFG_PSEUDO_BIT];
	assign cfgView.doubleRange = config_word_reg[adc_coding_pkg::CFG_RANGE_BIT];
	assign cfgView.twosComp    = config_word_reg[adc_coding_pkg::CFG_TWOS_BIT];
	assign cfgView.intRef      = config_word_reg[adc_coding_pkg::CFG_INTREF_BIT];
	assign cfgView.ifMode      = config_word_reg[adc_coding_pkg::CFG_MODE_HI:
	                                             adc_coding_pkg::CFG_MODE_LO];

	// ------------------------------------------------------------
	// input handling
	// ------------------------------------------------------------
	// samples are already scaled to the chosen range, so range needs no math here
	function automatic logic [16:0] rawOf(input logic [15:0] p,
	                                      input logic [15:0] n,
	                                      input logic        pseudo,
	                                      input logic        twos);
		logic [16:0] diff;
		logic [17:0] sum;
		diff = {1'b0, p} - {1'b0, n};
		// binary midscale is 7fff, but 0000 once the top bit flips
		sum  = (twos ? 18'h08000 : 18'h07fff) + {diff[16], diff};
		if (!pseudo)
			return {1'b0, p};
		// zero difference lands on midscale; clamp either side
		if (sum[17])
			return 17'h1ffff;
		if (sum[16])
			return 17'h0ffff;
		return sum[16:0];
	endfunction : rawOf

	logic [16:0] rawA;
	logic [16:0] rawB;
	assign rawA = rawOf(pos_input_a, neg_input_a, cfgView.pseudoDiff, cfgView.twosComp);
	assign rawB = rawOf(pos_input_b, neg_input_b, cfgView.pseudoDiff, cfgView.twosComp);

	// ------------------------------------------------------------
	// coders
	// ------------------------------------------------------------
	output_coder coderA (
		.sys_clk     (sys_clk),
		.reset       (reset),
		.clkEn       (clkEn),
		.sampleValid (sampleValid),
		.twosComp    (cfgView.twosComp),
		.rawSample   (rawA),
		.code        (result.codeA)
	);

	output_coder coderB (
		.sys_clk     (sys_clk),
		.reset       (reset),
		.clkEn       (clkEn),
		.sampleValid (sampleValid),
		.twosComp    (cfgView.twosComp),
		.rawSample   (rawB),
		.code        (result.codeB)
	);

endmodule : adc_config_coding
`default_nettype wire

// >>> dv/adc_config_coding_props.sv
// checker: port-level properties of the configuration and coding block
`timescale 1ns/100ps
`default_nettype none
module adc_config_coding_props #(
	parameter int CODE_W = adc_coding_pkg::CODE_W
) (
	// clock and control
	input wire logic                    sys_clk,
	input wire logic                    reset,
	input wire logic                    clkEn,
	input wire logic                    chipSelN,
	input wire logic                    sampleValid,
	// samples
	input wire logic [CODE_W-1:0]       pos_input_a,
	input wire logic [CODE_W-1:0]       neg_input_a,
	input wire logic [CODE_W-1:0]       pos_input_b,
	input wire logic [CODE_W-1:0]       neg_input_b,
	// results and configuration
	input wire adc_coding_pkg::result_pair_t result,
	input wire logic [11:0]             config_word_reg,
	input wire adc_coding_pkg::cfg_view_t cfgView
);
	logic take;
	logic pd;
	logic tc;
	assign take = clkEn && sampleValid;
	assign pd = cfgView.pseudoDiff;
	assign tc = cfgView.twosComp;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	AST_SE_BIN: assert property (take && !pd && !tc |=> result.codeA == $past(pos_input_a))
		else $error("single-ended binary code wrong");
	AST_TWOS_MSB: assert property (take && !pd && tc |=>
		result.codeB == {~$past(pos_input_b[15]), $past(pos_input_b[14:0])})
		else $error("twos complement code wrong");
	AST_PSEUDO_ZERO: assert property (take && pd && !tc && pos_input_a == neg_input_a
		|=> result.codeA == 16'h7fff) else $error("zero difference not midscale");
	AST_PSEUDO_TWOS_ZERO: assert property (take && pd && tc && pos_input_a == neg_input_a
		|=> result.codeA == 16'h0000) else $error("zero difference not twos midscale");
	AST_CLAMP_HI: assert property (take && pd && !tc && pos_input_b == 16'hffff
		&& neg_input_b == 16'h0000 |=> result.codeB == 16'hffff) else $error("no high clamp");
	AST_CLAMP_LO: assert property (take && pd && tc && pos_input_b == 16'h0000
		&& neg_input_b == 16'hffff |=> result.codeB == 16'h8000) else $error("no low clamp");
	AST_SAME_MODE: assert property (take && pos_input_a == pos_input_b
		&& neg_input_a == neg_input_b |=> result.codeA == result.codeB)
		else $error("channels coded differently");
	AST_HOLD: assert property (!take |=> $stable(result)) else $error("result moved");
	AST_CFG_AT_END: assert property (!$stable(config_word_reg) |-> $past(chipSelN))
		else $error("config changed inside a frame");
	AST_VIEW_MAP: assert property (cfgView == {config_word_reg[7], config_word_reg[9],
		config_word_reg[4], config_word_reg[6], config_word_reg[11:10]})
		else $error("config view mismatch");
endmodule : adc_config_coding_props
bind adc_config_coding adc_config_coding_props #(.CODE_W(CODE_W)) props (.sys_clk(sys_clk),
	.reset(reset), .clkEn(clkEn), .chipSelN(chipSelN), .sampleValid(sampleValid),
	.pos_input_a(pos_input_a), .neg_input_a(neg_input_a), .pos_input_b(pos_input_b),
	.neg_input_b(neg_input_b), .result(result), .config_word_reg(config_word_reg),
	.cfgView(cfgView));
`default_nettype wire

// >>> dv/host_serial_model.sv
// partner: host controller driving the serial command pins
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
	// clock
	input  wire logic sys_clk,
	// serial pins
	output logic      serialClk,
	output logic      chipSelN,
	output logic      serial_cmd_in
);
	initial begin
		serialClk = 1'b1;
		chipSelN = 1'b1;
		serial_cmd_in = 1'b1;
	end
	// half periods of 4 cycles: the pins are resynchronised inside the block
	task automatic sendFrame(input logic [15:0] word, input int nEdges);
		@(posedge sys_clk);
		#2 chipSelN = 1'b0;
		for (int i = 0; i < nEdges; i++) begin
			serial_cmd_in = (i < 16) ? word[15-i] : 1'b0; // op nibble first, low after
			repeat (4) @(posedge sys_clk);
			#2 serialClk = 1'b0; // one counted fall
			repeat (4) @(posedge sys_clk);
			#2 serialClk = 1'b1;
		end
		repeat (4) @(posedge sys_clk);
		#2 chipSelN = 1'b1;
		serial_cmd_in = ~serial_cmd_in; // toggled line, no stale bit
	endtask : sendFrame
endmodule : host_serial_model
`default_nettype wire

// >>> dv/dual_adc_input_and_output_coding_test.sv
// testbench: configuration frames and sample coding checks
`timescale 1ns/100ps
`default_nettype none
module dual_adc_input_and_output_coding_test;
	logic sys_clk, reset, clkEn, sampleValid, serialClk, chipSelN, serialIn;
	logic [15:0] posA, negA, posB, negB, readbackWord;
	logic [11:0] config_word_reg;
	logic [8:0] refA, refB;
	adc_coding_pkg::result_pair_t result;
	adc_coding_pkg::cfg_view_t cfgView;
	int fails = 0;
	int n_checks = 0;
	host_serial_model host (.sys_clk(sys_clk), .serialClk(serialClk), .chipSelN(chipSelN),
		.serial_cmd_in(serialIn));
	adc_config_coding dut (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
		.serialClk(serialClk), .chipSelN(chipSelN), .serial_cmd_in(serialIn),
		.sampleValid(sampleValid), .pos_input_a(posA), .neg_input_a(negA),
		.pos_input_b(posB), .neg_input_b(negB), .result(result),
		.config_word_reg(config_word_reg), .ref_level_a_reg(refA), .ref_level_b_reg(refB),
		.readbackWord(readbackWord), .cfgView(cfgView));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic results;
		if (fails == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic smp(input logic [15:0] pa, na, pb, nb, ea, eb);
		@(posedge sys_clk);
		#2 {posA, negA, posB, negB} = {pa, na, pb, nb};
		sampleValid = 1'b1;
		@(posedge sys_clk);
		#2 sampleValid = 1'b0;
		chk("codeA", ea, result.codeA);
		chk("codeB", eb, result.codeB);
	endtask : smp
	// frames settle a few cycles after the select pin rises
	task automatic frame(input logic [15:0] w, input int n, input logic [11:0] expCfg);
		host.sendFrame(w, n);
		repeat (10) @(posedge sys_clk);
		chk("config", {4'h0, expCfg}, {4'h0, config_word_reg});
	endtask : frame
	initial begin
		#2000000;
		fails++;
		results();
	end
	initial begin
		{clkEn, sampleValid, reset} = 3'b101;
		{posA, negA, posB, negB} = '0;
		repeat (3) @(posedge sys_clk);
		#2 reset = 1'b0;
		chk("view", 16'h0000, {10'h000, cfgView});
		smp(16'h0000, 16'h1234, 16'hffff, 16'h0000, 16'h0000, 16'hffff);
		smp(16'h7fff, 16'h0000, 16'h7fff, 16'h0000, 16'h7fff, 16'h7fff);
		frame(16'h8010, 32, 12'h010);
		smp(16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h8000, 16'h7fff);
		frame(16'h8090, 32, 12'h090);
		smp(16'h1234, 16'h1234, 16'h0000, 16'hffff, 16'h0000, 16'h8000);
		frame(16'h8280, 32, 12'h280);
		chk("view", 16'h0030, {10'h000, cfgView});
		smp(16'h8000, 16'h8000, 16'hffff, 16'h0000, 16'h7fff, 16'hffff);
		smp(16'h0000, 16'h8000, 16'h0000, 16'h8000, 16'h0000, 16'h0000);
		frame(16'h8011, 31, 12'h280);
		frame(16'h0011, 32, 12'h280);
		frame(16'hb011, 32, 12'h280);
		frame(16'h4011, 32, 12'h280);
		frame(16'h8440, 32, 12'h440);
		chk("view", 16'h0005, {10'h000, cfgView});
		frame(16'h8011, 32, 12'h440);
		frame(16'h8011, 48, 12'h011);
		frame(16'h9ab8, 32, 12'h011);
		chk("refA", 16'h0157, {7'h00, refA});
		frame(16'ha008, 32, 12'h011);
		chk("refB", 16'h0001, {7'h00, refB});
		frame(16'h1000, 48, 12'h011);
		chk("readback", 16'h1ab8, readbackWord);
		frame(16'h2000, 48, 12'h011);
		chk("readback", 16'h2008, readbackWord);
		frame(16'h3000, 48, 12'h011);
		chk("readback", 16'h3011, readbackWord);
		@(posedge sys_clk);
		#2 {clkEn, sampleValid, posA} = {2'b01, 16'h5555};
		repeat (3) @(posedge sys_clk);
		chk("frozen", 16'h0000, result.codeA);
		results();
	end
endmodule : dual_adc_input_and_output_coding_test
`default_nettype wire
